/* common/flash_ctrl_map.svh */
// Purpose: constants for the parallel flash host controller
// Assumes: 100 MHz clock, 10 ns period
// Notes:   definitions only
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
`define CLK_PERIOD_NS      32'd10
`define UNLOCK_ADDR_A      16'h5555
`define UNLOCK_ADDR_B      16'h2aaa
`define UNLOCK_DATA_A      16'h00aa
`define UNLOCK_DATA_B      16'h0055
`define CODE_PROGRAM       16'h00a0
`define CODE_ERASE_SETUP   16'h0080
`define CODE_SECTOR_ERASE  16'h0030
`define CODE_CHIP_ERASE    16'h0010
`define TOGGLE_BIT         6
`define POLL_BIT_POS       7
`define SECTOR_LSB         11
`define STROBE_LOW_NS      32'd40
`define STROBE_HIGH_NS     32'd40
`define READ_ACCESS_NS     32'd80
`define SETTLE_NS          32'd1000
`define STROBE_LOW_CYC     ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC    ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_CYC    ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYC         ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* common/flash_ctrl_pkg.sv */
// Purpose: types for the parallel flash host controller
// Assumes: nothing
// Notes:   constants live in flash_ctrl_map.svh
package flash_ctrl_pkg;
  typedef enum logic [1:0]
  {
    OP_READ         = 2'b00,
    OP_PROGRAM      = 2'b01,
    OP_SECTOR_ERASE = 2'b10,
    OP_CHIP_ERASE   = 2'b11
  } op_t;
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_WRITE  = 3'b001,
    ST_READ   = 3'b010,
    ST_POLL   = 3'b011,
    ST_CHECK  = 3'b100,
    ST_SETTLE = 3'b101,
    ST_DONE   = 3'b110
  } state_t;
endpackage : flash_ctrl_pkg

/* design/bus_cycle.sv */
// Purpose: one timed strobe cycle on the flash pins, write or read
// Assumes: start only while idle
// Notes:   chip select and the active strobe fall and rise together
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"
module bus_cycle
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] dq_in,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rdata,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [15:0]      a_out,
  output logic [15:0]      dq_out,
  output logic             dq_oe
);
  localparam logic [7:0] LOW_CYC  = 8'(`STROBE_LOW_CYC);
  localparam logic [7:0] HIGH_CYC = 8'(`STROBE_HIGH_CYC);
  localparam logic [7:0] RD_CYC   = 8'(`READ_ACCESS_CYC);
  logic [1:0]  ph_q, ph_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d;
  logic        done_d;
  logic [15:0] rdata_d, a_d, dqo_d;
  logic        ce_d, oe_d, we_d, dqoe_d;

  always_comb
  begin
    ph_d    = ph_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    done_d  = 1'b0;
    rdata_d = rdata;
    a_d     = a_out;
    dqo_d   = dq_out;
    ce_d    = ce_n;
    oe_d    = oe_n;
    we_d    = we_n;
    dqoe_d  = dq_oe;
    case (ph_q)
      2'd0:
      begin
        if (start)
        begin
          ph_d  = 2'd1;
          wr_d  = is_write;
          a_d   = addr;
          dqo_d = wdata;
          dqoe_d = is_write;
          ce_d  = 1'b0;
          we_d  = ~is_write;
          oe_d  = is_write;
          cnt_d = is_write ? LOW_CYC : RD_CYC;
        end
      end
      2'd1:
      begin
        if (cnt_q > 8'd1)
        begin
          cnt_d = cnt_q - 8'd1;
        end
        else
        begin
          // data still driven while the strobe rises
          if (!wr_q)
          begin
            rdata_d = dq_in;
          end
          ce_d  = 1'b1;
          we_d  = 1'b1;
          oe_d  = 1'b1;
          ph_d  = 2'd2;
          cnt_d = HIGH_CYC;
        end
      end
      2'd2:
      begin
        dqoe_d = 1'b0;
        if (cnt_q > 8'd1)
        begin
          cnt_d = cnt_q - 8'd1;
        end
        else
        begin
          ph_d   = 2'd0;
          done_d = 1'b1;
        end
      end
      default:
      begin
        ph_d = 2'd0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ph_q   <= 2'd0;
      cnt_q  <= 8'h00;
      wr_q   <= 1'b0;
      done   <= 1'b0;
      rdata  <= 16'h0000;
      a_out  <= 16'h0000;
      dq_out <= 16'h0000;
      ce_n   <= 1'b1;
      oe_n   <= 1'b1;
      we_n   <= 1'b1;
      dq_oe  <= 1'b0;
    end
    else
    begin
      ph_q   <= ph_d;
      cnt_q  <= cnt_d;
      wr_q   <= wr_d;
      done   <= done_d;
      rdata  <= rdata_d;
      a_out  <= a_d;
      dq_out <= dqo_d;
      ce_n   <= ce_d;
      oe_n   <= oe_d;
      we_n   <= we_d;
      dq_oe  <= dqoe_d;
    end
  end

  assign busy = (ph_q != 2'd0);
endmodule : bus_cycle

/* design/flash_host.sv */
// Purpose: host controller driving a 16-bit parallel flash by its pins
// Assumes: flash pins synchronous to CLK; one request at a time
// Notes:   completion found by the alternating status bit, reread twice
// Operation
// - host writes commands with write strobe low while select is low.
// - host programs a word only after its sector was erased; controller programs any requested word without checking.
// - program is three unlock cycles then address and data cycle.
// - during program, commands ignored; host only does status reads.
// - sector erase is six cycles ending with sector code and sector address.
// - chip erase is six cycles ending with chip code at command address.
// - during chip erase, commands ignored; host only does status reads.
// - on conflicting status, reread the location twice more before deciding.
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"
module flash_host
  import flash_ctrl_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  input  wire logic                REQ_VALID,
  input  wire flash_ctrl_pkg::op_t REQ_OP,
  input  wire logic [15:0]         REQ_ADDR,
  input  wire logic [15:0]         REQ_DATA,
  output logic                     REQ_READY,
  output logic                     RESP_VALID,
  output logic [15:0]              RESP_DATA,
  output logic                     RESP_ERROR,
  output logic                     FLASH_CE_N,
  output logic                     FLASH_OE_N,
  output logic                     FLASH_WE_N,
  output logic [15:0]              FLASH_A,
  output logic [15:0]              FLASH_DQ_OUT,
  output logic                     FLASH_DQ_OE,
  input  wire logic [15:0]         FLASH_DQ_IN
);
  import flash_ctrl_pkg::*;
  localparam logic [7:0] SETTLE_CYC = 8'(`SETTLE_CYC);

  state_t      st_q, st_d;
  op_t         op_q, op_d;
  logic [15:0] addr_q, addr_d, data_q, data_d;
  logic [2:0]  step_q, step_d;
  logic [2:0]  nsteps;
  logic [15:0] prev_q, prev_d;
  logic [1:0]  reread_q, reread_d;
  logic [7:0]  wait_q, wait_d;
  logic        start, is_wr, busy, done;
  logic [15:0] cyc_a, cyc_d, rdata;
  logic        rdy_d, rv_d, rerr_d;
  logic [15:0] rd_d;

  bus_cycle u_cycle
  (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .start    (start),
    .is_write (is_wr),
    .addr     (cyc_a),
    .wdata    (cyc_d),
    .dq_in    (FLASH_DQ_IN),
    .busy     (busy),
    .done     (done),
    .rdata    (rdata),
    .ce_n     (FLASH_CE_N),
    .oe_n     (FLASH_OE_N),
    .we_n     (FLASH_WE_N),
    .a_out    (FLASH_A),
    .dq_out   (FLASH_DQ_OUT),
    .dq_oe    (FLASH_DQ_OE)
  );

  // four writes for program, six for erase
  assign nsteps = (op_q == OP_PROGRAM) ? 3'd4 : 3'd6;

  always_comb
  begin
    cyc_a = `UNLOCK_ADDR_A;
    cyc_d = `UNLOCK_DATA_A;
    case (step_q)
      3'd0:
      begin
        cyc_a = `UNLOCK_ADDR_A;
        cyc_d = `UNLOCK_DATA_A;
      end
      3'd1, 3'd4:
      begin
        cyc_a = `UNLOCK_ADDR_B;
        cyc_d = `UNLOCK_DATA_B;
      end
      3'd2:
      begin
        cyc_a = `UNLOCK_ADDR_A;
        cyc_d = (op_q == OP_PROGRAM) ? `CODE_PROGRAM : `CODE_ERASE_SETUP;
      end
      3'd3:
      begin
        if (op_q == OP_PROGRAM)
        begin
          cyc_a = addr_q;
          cyc_d = data_q;
        end
      end
      3'd5:
      begin
        // sector select address in upper lines; fixed address
        if (op_q == OP_SECTOR_ERASE)
        begin
          cyc_a = {addr_q[15:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}};
          cyc_d = `CODE_SECTOR_ERASE;
        end
        else
        begin
          cyc_a = `UNLOCK_ADDR_A;
          cyc_d = `CODE_CHIP_ERASE;
        end
      end
      default:
      begin
        cyc_a = `UNLOCK_ADDR_A;
      end
    endcase
    if (st_q != ST_WRITE)
    begin
      cyc_a = addr_q;
    end
  end

  always_comb
  begin
    st_d     = st_q;
    op_d     = op_q;
    addr_d   = addr_q;
    data_d   = data_q;
    step_d   = step_q;
    prev_d   = prev_q;
    reread_d = reread_q;
    wait_d   = wait_q;
    start    = 1'b0;
    is_wr    = 1'b0;
    rdy_d    = 1'b0;
    rv_d     = 1'b0;
    rerr_d   = RESP_ERROR;
    rd_d     = RESP_DATA;
    case (st_q)
      ST_IDLE:
      begin
        rdy_d = 1'b1;
        if (REQ_VALID && REQ_READY)
        begin
          rdy_d  = 1'b0;
          op_d   = REQ_OP;
          addr_d = REQ_ADDR;
          data_d = REQ_DATA;
          step_d = 3'd0;
          rerr_d = 1'b0;
          st_d   = (REQ_OP == OP_READ) ? ST_READ : ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        // one strobe cycle per command word
        if (!busy && !done)
        begin
          start = 1'b1;
          is_wr = 1'b1;
        end
        if (done)
        begin
          if (step_q == nsteps - 3'd1)
          begin
            // status valid after the last strobe rise
            st_d     = ST_POLL;
            reread_d = 2'd0;
            prev_d   = 16'h0000;
            step_d   = 3'd0;
          end
          else
          begin
            step_d = step_q + 3'd1;
          end
        end
      end
      ST_READ:
      begin
        // read gated by select and output gate
        if (!busy && !done)
        begin
          start = 1'b1;
        end
        if (done)
        begin
          rd_d = rdata;
          st_d = ST_DONE;
        end
      end
      ST_POLL:
      begin
        if (!busy && !done)
        begin
          start = 1'b1;
        end
        if (done)
        begin
          prev_d = rdata;
          st_d   = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        if (!busy && !done)
        begin
          start = 1'b1;
        end
        if (done)
        begin
          prev_d = rdata;
          if (rdata[`TOGGLE_BIT] != prev_q[`TOGGLE_BIT])
          begin
            reread_d = 2'd0;
          end
          // two more steady reads before deciding
          else if (reread_q == 2'd1)
          begin
            if (op_q == OP_PROGRAM)
            begin
              rerr_d = (rdata[`POLL_BIT_POS] != data_q[`POLL_BIT_POS]);
            end
            else
            begin
              rerr_d = ~rdata[`POLL_BIT_POS];
            end
            wait_d = SETTLE_CYC;
            st_d   = ST_SETTLE;
          end
          else
          begin
            reread_d = reread_q + 2'd1;
          end
        end
      end
      ST_SETTLE:
      begin
        // allow the other bits to become valid
        if (wait_q > 8'd1)
        begin
          wait_d = wait_q - 8'd1;
        end
        else
        begin
          st_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        rv_d = 1'b1;
        st_d = ST_IDLE;
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      st_q       <= ST_IDLE;
      op_q       <= OP_READ;
      addr_q     <= 16'h0000;
      data_q     <= 16'h0000;
      step_q     <= 3'd0;
      prev_q     <= 16'h0000;
      reread_q   <= 2'd0;
      wait_q     <= 8'h00;
      REQ_READY  <= 1'b0;
      RESP_VALID <= 1'b0;
      RESP_DATA  <= 16'h0000;
      RESP_ERROR <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      op_q       <= op_d;
      addr_q     <= addr_d;
      data_q     <= data_d;
      step_q     <= step_d;
      prev_q     <= prev_d;
      reread_q   <= reread_d;
      wait_q     <= wait_d;
      REQ_READY  <= rdy_d;
      RESP_VALID <= rv_d;
      RESP_DATA  <= rd_d;
      RESP_ERROR <= rerr_d;
    end
  end
endmodule : flash_host

/* test/flash_host_props.sv */
// Purpose: pin and handshake checks for the flash host controller
// Assumes: bound to flash_host
// Notes:   pulse and read counts restart at each accepted request
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"
module flash_host_props
  import flash_ctrl_pkg::*;
(
  input wire logic                CLK,
  input wire logic                RESET_N,
  input wire logic                REQ_VALID,
  input wire logic                REQ_READY,
  input wire flash_ctrl_pkg::op_t REQ_OP,
  input wire logic                RESP_VALID,
  input wire logic                FLASH_CE_N,
  input wire logic                FLASH_OE_N,
  input wire logic                FLASH_WE_N,
  input wire logic [15:0]         FLASH_A,
  input wire logic [15:0]         FLASH_DQ_OUT,
  input wire logic                FLASH_DQ_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  op_t        op_q, op_d;
  logic       we_q, oe_q;
  logic [3:0] wr_q, wr_d, rd_q, rd_d;
  always_comb
  begin
    op_d = op_q;
    wr_d = wr_q + 4'(we_q && !FLASH_WE_N);
    rd_d = rd_q + 4'(oe_q && !FLASH_OE_N && rd_q != 4'hf);
    if (REQ_VALID && REQ_READY)
    begin
      op_d = REQ_OP;
      wr_d = 4'h0;
      rd_d = 4'h0;
    end
  end
  always_ff @(posedge CLK)
  begin
    op_q <= RESET_N ? op_d : OP_READ;
    wr_q <= RESET_N ? wr_d : 4'h0;
    rd_q <= RESET_N ? rd_d : 4'h0;
    we_q <= FLASH_WE_N;
    oe_q <= FLASH_OE_N;
  end
  AST_WE_IN_CE: assert property (!FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N)
    else $error("write strobe outside select");
  AST_NO_CONTENTION: assert property (FLASH_DQ_OE |-> FLASH_OE_N)
    else $error("host drives data while output gate low");
  AST_STROBE_WIDTH: assert property ($fell(FLASH_WE_N) |-> (!FLASH_WE_N) [*4] ##1 FLASH_WE_N)
    else $error("write strobe not four cycles low");
  AST_DATA_AT_RISE: assert property ($rose(FLASH_WE_N) |-> FLASH_DQ_OE && $stable(FLASH_DQ_OUT))
    else $error("data released before strobe rise");
  AST_FIRST_UNLOCK: assert property (REQ_VALID && REQ_READY && REQ_OP != OP_READ |->
    ##[1:4] (!FLASH_WE_N && FLASH_A == `UNLOCK_ADDR_A && FLASH_DQ_OUT == `UNLOCK_DATA_A))
    else $error("write operation not opened by unlock cycle");
  AST_PROGRAM_PULSES: assert property (RESP_VALID && op_q == OP_PROGRAM |-> wr_q == 4'd4)
    else $error("program did not use four write pulses");
  AST_ERASE_PULSES: assert property (RESP_VALID && op_q[1] |-> wr_q == 4'd6)
    else $error("erase did not use six write pulses");
  AST_REREADS: assert property (RESP_VALID && op_q != OP_READ |-> rd_q >= 4'd3)
    else $error("completion decided on fewer than three reads");
  COV_READ: cover property (RESP_VALID && op_q == OP_READ);
  COV_PROGRAM: cover property (RESP_VALID && op_q == OP_PROGRAM);
  COV_SECTOR: cover property (RESP_VALID && op_q == OP_SECTOR_ERASE);
  COV_CHIP: cover property (RESP_VALID && op_q == OP_CHIP_ERASE);
endmodule : flash_host_props

/* test/flash_model.sv */
// Purpose: behavioural 16-bit parallel flash facing the host
// Assumes: times in ns; slow stretches busy times
// Notes:   a released bus shows the inverse of its last value
`timescale 1ns/100ps
module flash_model
(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        slow,
  input  wire logic [15:0] a,
  input  wire logic [15:0] din,
  output logic      [15:0] dout
);
  logic [15:0] mem [0:65535];
  logic [15:0] lat_a, tgt, last;
  logic        tog, erasing;
  int          step;
  realtime     end_t;
  wire         wr = ce_n | we_n;
  wire         rd = ce_n | oe_n;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hffff;
    step = 0;
    end_t = 0;
    tog = 1'b0;
    last = 16'h0;
  end
  task automatic launch(input logic [15:0] t, input logic e, input int ns);
    tgt = t;
    erasing = e;
    end_t = $realtime + (slow ? ns * 9 / 2 : ns);
  endtask : launch
  task automatic accept(input logic [15:0] ad, input logic [15:0] d);
    logic c5;
    c5 = ad == 16'h5555;
    case (step)
      0, 4: step = (c5 && d[7:0] == 8'haa) ? step + 1 : 0;
      1, 5: step = (ad == 16'h2aaa && d[7:0] == 8'h55) ? step + 1 : 0;
      2: step = !c5 ? 0 : d[7:0] == 8'ha0 ? 3 : d[7:0] == 8'h80 ? 4 : 0;
      3:
      begin
        step = 0;
        mem[ad] = mem[ad] & d;
        launch(d, 1'b0, 2000);
      end
      default:
      begin
        step = 0;
        if (d[7:0] == 8'h30)
          for (int i = 0; i < 2048; i++) mem[{ad[15:11], 11'(i)}] = 16'hffff;
        if (d[7:0] == 8'h30 || (c5 && d[7:0] == 8'h10))
          launch(16'hffff, 1'b1, d[5] ? 8000 : 20000);
        if (c5 && d[7:0] == 8'h10)
          foreach (mem[i]) mem[i] = 16'hffff;
      end
    endcase
  endtask : accept
  // address at last fall, data at first rise
  always @(negedge wr) lat_a = a;
  always @(posedge wr) if ($realtime >= end_t) accept(lat_a, din);
  always @(rd)
  begin
    // driven only while selected and gated
    if (rd !== 1'b0) dout = ~last;
    else if ($realtime < end_t)
    begin
      tog = ~tog;
      dout = {~tgt[15:8], erasing ? 1'b0 : ~tgt[7], tog, ~tgt[5:0]};
    end
    // bits other than 7 and 6 settle a microsecond later
    else if ($realtime < end_t + 1000) dout = mem[a] ^ 16'hff3f;
    else dout = mem[a];
    last = dout;
  end
endmodule : flash_model

/* test/flash_host_bench.sv */
// Purpose: self-checking bench for the flash host controller
// Assumes: device model on the flash pins
// Notes:   inputs change on the falling clock edge
`timescale 1ns/100ps
module flash_host_bench;
  import flash_ctrl_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, slow = 1'b0;
  op_t         req_op = OP_READ;
  logic [15:0] req_addr = 16'h0, req_data = 16'h0, a;
  logic [15:0] shadow [logic [15:0]];
  wire         req_ready, resp_valid, resp_error, ce_n, oe_n, we_n, dq_oe;
  wire  [15:0] resp_data, fa, dq_out, mdout;
  wire  [15:0] dq = dq_oe ? dq_out : mdout;
  int          fails = 0, n_compared = 0;
  always #5 clk = ~clk;
  flash_host u_dut
  (
    .CLK(clk), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ_OP(req_op),
    .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_READY(req_ready),
    .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .RESP_ERROR(resp_error),
    .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_A(fa),
    .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dq)
  );
  flash_model u_dev
  (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .slow(slow), .a(fa), .din(dq), .dout(mdout)
  );
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic fail(input string m);
    fails++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
  endtask : check_word
  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask : check_flag
  function automatic logic [15:0] exp_word(input logic [15:0] ad);
    return shadow.exists(ad) ? shadow[ad] : 16'hffff;
  endfunction : exp_word
  task automatic run(input op_t op, input logic [15:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req_op = op;
    req_addr = ad;
    req_data = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 20000) fail("no response");
  endtask : run
  task automatic prog(input logic [15:0] ad, input logic [15:0] d);
    logic [15:0] now;
    now = exp_word(ad) & d;
    run(OP_PROGRAM, ad, d);
    // polling agrees when cell took data
    check_flag(resp_error, now[7] !== d[7]);
    shadow[ad] = now;
  endtask : prog
  task automatic erase(input op_t op, input logic [15:0] ad);
    run(op, ad, 16'h0);
    check_flag(resp_error, 1'b0);
    foreach (shadow[k])
      if (op == OP_CHIP_ERASE || k[15:11] == ad[15:11]) shadow[k] = 16'hffff;
  endtask : erase
  task automatic rd(input logic [15:0] ad);
    run(OP_READ, ad, 16'($urandom));
    check_word(resp_data, exp_word(ad));
  endtask : rd
  initial
  begin
    void'($urandom(47081));
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      a = {4'h1, 1'(i), 11'($urandom)};
      prog(a, 16'($urandom));
      rd(a);
    end
    slow = 1'b1;
    prog(16'h17ff, 16'h1234);
    prog(16'h1800, 16'h00ff);
    erase(OP_SECTOR_ERASE, 16'h1800);
    slow = 1'b0;
    rd(16'h17ff);
    rd(16'h1800);
    prog(16'h0100, 16'h0000);
    prog(16'h0100, 16'h0080);
    rd(16'h0100);
    erase(OP_CHIP_ERASE, 16'h0000);
    rd(16'h17ff);
    rd(16'h0100);
    final_report;
  end
  initial
  begin
    #600000;
    fail("watchdog");
    final_report;
  end
endmodule : flash_host_bench
bind flash_host flash_host_props u_props
(
  .CLK(CLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .REQ_OP(REQ_OP), .RESP_VALID(RESP_VALID), .FLASH_CE_N(FLASH_CE_N),
  .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N), .FLASH_A(FLASH_A),
  .FLASH_DQ_OUT(FLASH_DQ_OUT), .FLASH_DQ_OE(FLASH_DQ_OE)
);
